//--- dv/mrc_net_model.sv
// Purpose: Line side model driving frame, sent-frame and pause events
// Assumes: Events are one-cycle pulses on the design clock
// Notes:   Qualifiers are inverted once their pulse ends, so stale values never look valid
`timescale 1ns/1ps
module mrc_net_model (
  input  wire logic           clk_i,     // Design clock
  output logic                tx_done_o, // Frame sent
  output mrc_pkg::mrc_txstat_s tx_stat_o, // Sent frame status
  output logic                sof_o,     // Frame start
  output logic                eof_o,     // Frame end
  output mrc_pkg::mrc_rxinfo_s info_o,    // Frame facts
  output logic                prx_o,     // Pause received
  output logic [15:0]         pq_o       // Pause time
);
  import mrc_pkg::*;
  initial begin
    tx_done_o = 1'b0;
    tx_stat_o = '0;
    sof_o     = 1'b0;
    eof_o     = 1'b0;
    info_o    = '0;
    prx_o     = 1'b0;
    pq_o      = 16'h0;
  end
  task automatic start();
    @(posedge clk_i);
    sof_o <= 1'b1;
    @(posedge clk_i);
    sof_o <= 1'b0;
  endtask : start
  // End at least one cycle after start
  task automatic finish(input mrc_rxinfo_s i);
    @(posedge clk_i);
    eof_o  <= 1'b1;
    info_o <= i;
    @(posedge clk_i);
    eof_o  <= 1'b0;
    info_o <= ~i;
  endtask : finish
  task automatic sent(input mrc_txstat_s s);
    @(posedge clk_i);
    tx_done_o <= 1'b1;
    tx_stat_o <= s;
    @(posedge clk_i);
    tx_done_o <= 1'b0;
    tx_stat_o <= ~s;
  endtask : sent
  task automatic pause(input logic [15:0] q);
    @(posedge clk_i);
    prx_o <= 1'b1;
    pq_o  <= q;
    @(posedge clk_i);
    prx_o <= 1'b0;
    pq_o  <= ~q;
  endtask : pause
endmodule : mrc_net_model

//--- dv/test_mrc_top.sv
// Purpose: Self-checking bench for the receive control and transmit status block
// Assumes: APB master with one request at a time; line events from the model
// Notes:   Filter cases run from a table; reset and odd cases follow by hand
`timescale 1ns/1ps
module test_mrc_top;
  import mrc_pkg::*;
  typedef struct packed {
    logic [15:0] ctrl;
    mrc_rxinfo_s info;
    logic        keep;
  } mrc_row_s;
  logic        clk_i, rst_i, psel, penable, pwrite, pready, pslverr, fdx;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        er, tx_done, sof, eof, prx, keep, drop, running, qclr, hold;
  logic [15:0] pq, ptr, kept;
  mrc_txstat_s tx_stat;
  mrc_rxinfo_s info;
  int          err_count, comparisons;
  // --------------------------------------------------------------
  // Filter table: control bits, frame facts, admitted
  // --------------------------------------------------------------
  localparam mrc_row_s ROWS [17] = '{
    '{16'h0020, 13'h1200, 1'b1},
    '{16'h0000, 13'h1200, 1'b0},
    '{16'h0800, 13'h1100, 1'b1},
    '{16'h0100, 13'h0880, 1'b1},
    '{16'h0040, 13'h0800, 1'b1},
    '{16'h0080, 13'h0C00, 1'b1},
    '{16'h0040, 13'h0C00, 1'b1},
    '{16'h0010, 13'h1000, 1'b1},
    '{16'h0022, 13'h1000, 1'b1},
    '{16'h0022, 13'h1200, 1'b0},
    '{16'h0010, 13'h1040, 1'b0},
    '{16'h0210, 13'h1040, 1'b1},
    '{16'h4010, 13'h1030, 1'b0},
    '{16'h0010, 13'h1030, 1'b1},
    '{16'h2010, 13'h100C, 1'b0},
    '{16'h1010, 13'h1003, 1'b0},
    '{16'h0100, 13'h0C80, 1'b0}
  };
  mrc_top i_mrc_top (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .tx_done_i(tx_done), .tx_stat_i(tx_stat),
    .rx_sof_i(sof), .rx_eof_i(eof), .rx_info_i(info), .pause_rx_i(prx),
    .pause_quanta_i(pq), .full_duplex_i(fdx), .rx_keep_o(keep), .rx_drop_o(drop),
    .rx_running_o(running), .rx_qclear_o(qclr), .rx_frame_ptr_o(ptr), .tx_hold_o(hold)
  );
  mrc_net_model i_mrc_net_model (
    .clk_i(clk_i), .tx_done_o(tx_done), .tx_stat_o(tx_stat), .sof_o(sof),
    .eof_o(eof), .info_o(info), .prx_o(prx), .pq_o(pq)
  );
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  // Holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    complete_run();
  end
  initial begin
    rst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    fdx = 1'b0;
    kept = 16'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 17; i++) begin
      apb(1'b1, ADDR_RX_CTRL, {16'h0, ROWS[i].ctrl | 16'h0001});
      i_mrc_net_model.start();
      i_mrc_net_model.finish(ROWS[i].info);
      #1;
      kept = kept + ROWS[i].keep;
      chk("keep", ROWS[i].keep, keep);
      chk("drop", !ROWS[i].keep, drop);
      chk("ptr", kept, ptr);
    end
    $display("test filter table done");
    i_mrc_net_model.sent('{1'b1, 1'b0, 6'h3F});
    i_mrc_net_model.sent('{1'b0, 1'b1, 6'h01});
    apb(1'b0, ADDR_TX_STATUS, 32'h0);
    chk("txs", 32'h0000_1001, rd);
    i_mrc_net_model.sent('{1'b1, 1'b0, 6'h2A});
    apb(1'b1, ADDR_TX_STATUS, 32'hFFFF_FFFF);
    chk("txs_wr_err", 32'h0, er);
    apb(1'b0, ADDR_TX_STATUS, 32'h0);
    chk("txs_ro", 32'h0000_202A, rd);
    apb(1'b0, 12'h1FC, 32'h0);
    chk("unmapped_err", 32'h1, er);
    chk("unmapped_rd", 32'h0, rd);
    $display("test tx status done");
    apb(1'b1, ADDR_RX_CTRL, 32'h0000_0000);
    apb(1'b1, ADDR_RX_CTRL, 32'h0000_8000);
    i_mrc_net_model.start();
    i_mrc_net_model.finish(13'h1000);
    #1;
    chk("flush_keep", 32'h0, keep);
    chk("qclear", 32'h1, qclr);
    chk("flush_ptr", 32'h0, ptr);
    apb(1'b1, ADDR_RX_CTRL, 32'h0000_0000);
    apb(1'b0, ADDR_RX_CTRL, 32'h0);
    chk("qclear_off", 32'h0, qclr);
    $display("test flush done");
    apb(1'b1, ADDR_RX_CTRL, 32'h0000_0011);
    i_mrc_net_model.start();
    apb(1'b1, ADDR_RX_CTRL, 32'h0000_0010);
    @(posedge clk_i);
    #1;
    chk("drain_run", 32'h1, running);
    i_mrc_net_model.finish(13'h1000);
    #1;
    chk("drain_keep", 32'h1, keep);
    i_mrc_net_model.start();
    i_mrc_net_model.finish(13'h1000);
    #1;
    chk("stop_run", 32'h0, running);
    chk("stop_keep", 32'h0, keep);
    $display("test drain done");
    apb(1'b1, ADDR_RX_CTRL, 32'h0000_0400);
    fdx <= 1'b1;
    i_mrc_net_model.pause(16'h0002);
    #1;
    chk("hold_on", 32'h1, hold);
    repeat (1279) @(posedge clk_i);
    #1;
    chk("hold_mid", 32'h1, hold);
    repeat (11) @(posedge clk_i);
    #1;
    chk("hold_off", 32'h0, hold);
    apb(1'b1, ADDR_RX_CTRL, 32'h0000_0000);
    fdx <= 1'b0;
    i_mrc_net_model.pause(16'h0002);
    #1;
    chk("hold_half", 32'h0, hold);
    $display("test pause done");
    apb(1'b1, ADDR_RX_CTRL, 32'hFFFF_7BFE);
    apb(1'b0, ADDR_RX_CTRL, 32'h0);
    chk("rxc_rw", 32'h0000_7BFE, rd);
    apb(1'b1, ADDR_RX_CTRL, 32'h0000_0001);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("rst_run", 32'h0, running);
    chk("rst_ptr", 32'h0, ptr);
    apb(1'b0, ADDR_RX_CTRL, 32'h0);
    chk("rst_rxc", 32'h0, rd);
    apb(1'b0, ADDR_TX_STATUS, 32'h0);
    chk("rst_txs", 32'h0, rd);
    $display("test reset done");
    complete_run();
  end
endmodule : test_mrc_top

//--- hw/mrc_pkg.sv
// Purpose: Shared constants and carriers for the MAC receive control block
// Assumes: 125 MHz clock, APB with 32-bit data, one word per register
// Notes:   Register offsets are word indices; byte address is four times them
package mrc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_TX_STATUS = 8'h72;
  localparam logic [7:0]  IDX_RX_CTRL   = 8'h74;
  localparam logic [11:0] ADDR_TX_STATUS = {2'b00, IDX_TX_STATUS, 2'b00};
  localparam logic [11:0] ADDR_RX_CTRL   = {2'b00, IDX_RX_CTRL, 2'b00};

  // Transmit status fields
  localparam int TXS_LATE_BIT = 13;
  localparam int TXS_MAX_BIT  = 12;
  localparam int TXS_FID_MSB  = 5;
  localparam logic [15:0] TXS_RESET = 16'h0000;

  // Receive control fields
  localparam int RXC_FLUSH = 15;
  localparam int RXC_UDPCK = 14;
  localparam int RXC_TCPCK = 13;
  localparam int RXC_IPCK  = 12;
  localparam int RXC_UFILT = 11;
  localparam int RXC_PAUSE = 10;
  localparam int RXC_CRCOK = 9;
  localparam int RXC_MFILT = 8;
  localparam int RXC_BCAST = 7;
  localparam int RXC_MALL  = 6;
  localparam int RXC_UCAST = 5;
  localparam int RXC_ALL   = 4;
  localparam int RXC_INV   = 1;
  localparam int RXC_EN    = 0;
  localparam logic [15:0] RXC_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 8;
  localparam int PAUSE_QUANTUM_NS  = 5120;  // 512 bit times at 100 Mb/s
  localparam int PAUSE_QUANTUM_CYC = PAUSE_QUANTUM_NS / CLK_PERIOD_NS;
  localparam logic [9:0] QCNT_LAST = 10'(PAUSE_QUANTUM_CYC - 1);

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       late_col;
    logic       max_col;
    logic [5:0] fid;
  } mrc_txstat_s;

  typedef struct packed {
    logic ucast;
    logic mcast;      // Set for broadcast too
    logic bcast;
    logic station_hit;
    logic ufilt_pass;
    logic mfilt_pass;
    logic crc_err;
    logic is_udp;
    logic udp_bad;
    logic is_tcp;
    logic tcp_bad;
    logic is_ip;
    logic ip_bad;
  } mrc_rxinfo_s;

  typedef enum logic [2:0] {
    RX_STOP  = 3'b001,
    RX_RUN   = 3'b010,
    RX_DRAIN = 3'b100
  } mrc_rxst_e;

endpackage : mrc_pkg

//--- hw/mrc_top.sv
// Purpose: Last transmit status capture and receive control for a MAC
// Assumes: Frame events come from logic on clk_i; no synchronisers needed
// Notes:   Zero-wait APB slave; every access completes in two cycles
//
// Functional notes
// [R01] Status reflects only the latest sent frame
// [R02] Late collision sets status bit 13
// [R03] Maximum collision sets status bit 12
// [R04] Bits 5..0 carry the frame identifier
// [R05] Flush clears queue and frame pointer
// [R06] Host disables receiver before flushing
// [R07] Bit 14 drops UDP frames with bad checksum
// [R08] Bit 13 drops TCP frames with bad checksum
// [R09] Bit 12 drops IP frames with bad header checksum
// [R10] Bit 11 admits unicast passing address filter
// [R11] Bit 10 honours pause in full duplex
// [R12] Host keeps bit 10 zero in half duplex
// [R13] Bit 9 admits CRC error frames
// [R14] Bit 8 admits multicast passing address filter
// [R15] Bit 7 admits all broadcast frames
// [R16] Bit 6 admits all multicast and broadcast
// [R17] Bit 5 admits unicast matching station address
// [R18] Bit 4 admits every frame
// [R19] Bit 1 inverts the address check
// [R20] Bit 0 runs receiver; stop after frame
// [R21] Writes to transmit status are ignored
`timescale 1ns/1ps
module mrc_top (
  input  wire logic                 clk_i,          // 125 MHz clock
  input  wire logic                 rst_i,          // Synchronous reset
  input  wire logic                 psel_i,         // APB select
  input  wire logic                 penable_i,      // APB enable
  input  wire logic                 pwrite_i,       // APB direction
  input  wire logic [11:0]          paddr_i,        // APB byte address
  input  wire logic [31:0]          pwdata_i,       // APB write data
  output logic      [31:0]          prdata_o,       // APB read data
  output logic                      pready_o,       // APB ready
  output logic                      pslverr_o,      // APB error
  input  wire logic                 tx_done_i,      // Frame sent pulse
  input  wire mrc_pkg::mrc_txstat_s tx_stat_i,      // Status of sent frame
  input  wire logic                 rx_sof_i,       // Frame start pulse
  input  wire logic                 rx_eof_i,       // Frame end pulse
  input  wire mrc_pkg::mrc_rxinfo_s rx_info_i,      // Frame facts at end
  input  wire logic                 pause_rx_i,     // Pause frame received
  input  wire logic [15:0]          pause_quanta_i, // Pause time
  input  wire logic                 full_duplex_i,  // Link is full duplex
  output logic                      rx_keep_o,      // Frame admitted pulse
  output logic                      rx_drop_o,      // Frame discarded pulse
  output logic                      rx_running_o,   // Receiver running
  output logic                      rx_qclear_o,    // Clear queue memory
  output logic      [15:0]          rx_frame_ptr_o, // Receive frame pointer
  output logic                      tx_hold_o       // Hold transmit queue
);
  import mrc_pkg::*;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [15:0] txs_q, txs_d;
  logic [15:0] rxc_q, rxc_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ready_q, ready_d;
  logic        err_q, err_d;
  logic        setup;
  logic        wr_acc;

  assign setup  = psel_i && !penable_i;
  assign wr_acc = psel_i && penable_i && pready_o && pwrite_i;

  // Decode and read data are taken in setup so the access phase is
  // answered from flops in its first cycle
  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d   = 1'b0;
    ready_d = setup;
    if (setup) begin
      unique case (paddr_i)
        ADDR_TX_STATUS: rdata_d = {16'h0000, txs_q};
        ADDR_RX_CTRL:   rdata_d = {16'h0000, rxc_q};
        default:        err_d   = 1'b1;
      endcase
    end
  end

  always_comb begin
    rxc_d = rxc_q;
    if (wr_acc && paddr_i == ADDR_RX_CTRL) begin
      rxc_d = pwdata_i[15:0];
    end
  end

  // Writes to the status word are never decoded as updates  [R21]
  always_comb begin
    txs_d = txs_q;
    if (tx_done_i) begin
      txs_d = TXS_RESET; // R01
      txs_d[TXS_LATE_BIT] = tx_stat_i.late_col; // R02
      txs_d[TXS_MAX_BIT]  = tx_stat_i.max_col; // R03
      txs_d[TXS_FID_MSB:0] = tx_stat_i.fid; // R04
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txs_q   <= TXS_RESET;
      rxc_q   <= RXC_RESET;
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      txs_q   <= txs_d;
      rxc_q   <= rxc_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q   <= err_d;
    end
  end

  assign prdata_o  = rdata_q;
  assign pready_o  = ready_q;
  assign pslverr_o = err_q;

  // ----------------------------------------------------------------
  // Receive state and frame admission
  // ----------------------------------------------------------------
  mrc_rxst_e   st_q, st_d;
  logic        inframe_q, inframe_d;
  logic        keep_q, keep_d;
  logic        drop_q, drop_d;
  logic [15:0] ptr_q, ptr_d;
  logic        running_q, running_d;
  logic        flush;
  logic        addr_ok;
  logic        cksum_ok;
  logic        crc_ok;

  assign flush = rxc_q[RXC_FLUSH];

  // Filter decision for one frame's destination
  function automatic logic addr_pass(input logic [15:0] c, input mrc_rxinfo_s f);
    logic base;
    base = (f.bcast && c[RXC_BCAST]) // R15
        || (f.mcast && c[RXC_MALL]) // R16
        || (f.mcast && !f.bcast && c[RXC_MFILT] && f.mfilt_pass) // R14
        || (f.ucast && c[RXC_UCAST] && f.station_hit) // R17
        || (f.ucast && c[RXC_UFILT] && f.ufilt_pass); // R10
    if (c[RXC_INV]) begin
      base = !base; // R19
    end
    return base || c[RXC_ALL]; // R18
  endfunction : addr_pass

  assign addr_ok  = addr_pass(rxc_q, rx_info_i);
  assign cksum_ok = !(rxc_q[RXC_UDPCK] && rx_info_i.is_udp && rx_info_i.udp_bad) // R07
                 && !(rxc_q[RXC_TCPCK] && rx_info_i.is_tcp && rx_info_i.tcp_bad) // R08
                 && !(rxc_q[RXC_IPCK] && rx_info_i.is_ip && rx_info_i.ip_bad); // R09
  assign crc_ok   = !rx_info_i.crc_err || rxc_q[RXC_CRCOK]; // R13

  always_comb begin
    st_d      = st_q;
    inframe_d = inframe_q;
    keep_d    = 1'b0;
    drop_d    = 1'b0;
    ptr_d     = ptr_q;
    // Frames are only taken at a start seen while running
    if (rx_sof_i && st_q == RX_RUN && !flush) begin
      inframe_d = 1'b1;
    end
    if (rx_eof_i && inframe_q) begin
      inframe_d = 1'b0;
      if (addr_ok && cksum_ok && crc_ok && !flush) begin
        keep_d = 1'b1;
        ptr_d  = ptr_q + 16'h0001;
      end else begin
        drop_d = 1'b1;
      end
    end
    unique case (st_q)
      RX_STOP: begin
        if (rxc_q[RXC_EN]) begin
          st_d = RX_RUN; // R20
        end
      end
      RX_RUN: begin
        if (!rxc_q[RXC_EN]) begin
          st_d = inframe_d ? RX_DRAIN : RX_STOP; // R20
        end
      end
      RX_DRAIN: begin
        if (!inframe_d) begin
          st_d = rxc_q[RXC_EN] ? RX_RUN : RX_STOP; // R20
        end
      end
      default: st_d = RX_STOP;
    endcase
    // Flush overrides the pointer and frame tracking, so a stale frame cannot land afterwards
    if (flush) begin
      ptr_d     = 16'h0000; // R05
      inframe_d = 1'b0;
    end
    running_d = (st_d != RX_STOP); // R20
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q      <= RX_STOP;
      inframe_q <= 1'b0;
      keep_q    <= 1'b0;
      drop_q    <= 1'b0;
      ptr_q     <= 16'h0000;
      running_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      inframe_q <= inframe_d;
      keep_q    <= keep_d;
      drop_q    <= drop_d;
      ptr_q     <= ptr_d;
      running_q <= running_d;
    end
  end

  // Flush outputs straight from the control flop  [R05]
  assign rx_qclear_o    = rxc_q[RXC_FLUSH];
  assign rx_frame_ptr_o = ptr_q;
  assign rx_keep_o      = keep_q;
  assign rx_drop_o      = drop_q;
  assign rx_running_o   = running_q;

  // ----------------------------------------------------------------
  // Pause timer
  // ----------------------------------------------------------------
  logic [15:0] pq_q, pq_d;
  logic [9:0]  qc_q, qc_d;
  logic        hold_q, hold_d;
  logic        qtick;

  // One pulse per pause quantum; half duplex never loads the timer
  assign qtick = (qc_q == QCNT_LAST);

  always_comb begin
    pq_d = pq_q;
    qc_d = qtick ? 10'h000 : qc_q + 10'h001;
    if (pause_rx_i && rxc_q[RXC_PAUSE] && full_duplex_i) begin
      pq_d = pause_quanta_i; // R11
      qc_d = 10'h000;
    end else if (qtick && pq_q != 16'h0000) begin
      pq_d = pq_q - 16'h0001;
    end
    hold_d = (pq_d != 16'h0000); // R11
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pq_q   <= 16'h0000;
      qc_q   <= 10'h000;
      hold_q <= 1'b0;
    end else begin
      pq_q   <= pq_d;
      qc_q   <= qc_d;
      hold_q <= hold_d;
    end
  end

  assign tx_hold_o = hold_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_tx_late;
    @(posedge clk_i) disable iff (rst_i)
      tx_done_i |=> txs_q[TXS_LATE_BIT] == $past(tx_stat_i.late_col);
  endproperty
  a_tx_late: assert property (p_tx_late) else $error("late flag wrong"); // R02

  property p_tx_max;
    @(posedge clk_i) disable iff (rst_i)
      tx_done_i |=> txs_q[TXS_MAX_BIT] == $past(tx_stat_i.max_col);
  endproperty
  a_tx_max: assert property (p_tx_max) else $error("max flag wrong"); // R03

  property p_tx_fid;
    @(posedge clk_i) disable iff (rst_i)
      tx_done_i |=> txs_q[TXS_FID_MSB:0] == $past(tx_stat_i.fid) && txs_q[11:6] == 6'h00;
  endproperty
  a_tx_fid: assert property (p_tx_fid) else $error("frame id wrong"); // R04

  // The reset edge is excluded: its sampled word is still the pre-reset one
  property p_tx_stable;
    @(posedge clk_i) disable iff (rst_i)
      !tx_done_i && !rst_i |=> $stable(txs_q);
  endproperty
  a_tx_stable: assert property (p_tx_stable) else $error("status moved"); // R21

  property p_flush;
    @(posedge clk_i) disable iff (rst_i)
      rxc_q[RXC_FLUSH] |=> ptr_q == 16'h0000 && !keep_q;
  endproperty
  a_flush: assert property (p_flush) else $error("flush ignored"); // R05

  property p_crc;
    @(posedge clk_i) disable iff (rst_i)
      rx_eof_i && rx_info_i.crc_err && !rxc_q[RXC_CRCOK] |=> !keep_q;
  endproperty
  a_crc: assert property (p_crc) else $error("crc frame kept"); // R13

  property p_all;
    @(posedge clk_i) disable iff (rst_i)
      rx_eof_i && inframe_q && rxc_q[RXC_ALL] && crc_ok && cksum_ok && !flush
      |=> keep_q;
  endproperty
  a_all: assert property (p_all) else $error("promiscuous drop"); // R18

  property p_drain;
    @(posedge clk_i) disable iff (rst_i)
      st_q == RX_RUN && inframe_q && !rxc_q[RXC_EN] && !rx_eof_i && !flush
      |=> rx_running_o;
  endproperty
  a_drain: assert property (p_drain) else $error("stopped mid frame"); // R20

  property p_pause;
    @(posedge clk_i) disable iff (rst_i)
      pause_rx_i && rxc_q[RXC_PAUSE] && full_duplex_i && pause_quanta_i != 16'h0000
      |=> tx_hold_o [*2];
  endproperty
  a_pause: assert property (p_pause) else $error("pause not held"); // R11

  property p_udp;
    @(posedge clk_i) disable iff (rst_i)
      rx_eof_i && rxc_q[RXC_UDPCK] && rx_info_i.is_udp && rx_info_i.udp_bad |=> !keep_q;
  endproperty
  a_udp: assert property (p_udp) else $error("bad udp kept"); // R07

  property p_ipck;
    @(posedge clk_i) disable iff (rst_i)
      rx_eof_i && rxc_q[RXC_IPCK] && rx_info_i.is_ip && rx_info_i.ip_bad |=> !keep_q;
  endproperty
  a_ipck: assert property (p_ipck) else $error("bad ip header kept"); // R09

  property p_run;
    @(posedge clk_i) disable iff (rst_i)
      st_q == RX_STOP && rxc_q[RXC_EN] && !rst_i |=> rx_running_o;
  endproperty
  a_run: assert property (p_run) else $error("receiver not started"); // R20

  c_keep:  cover property (@(posedge clk_i) disable iff (rst_i) keep_q);
  c_drain: cover property (@(posedge clk_i) disable iff (rst_i) st_q == RX_DRAIN);
  c_hold:  cover property (@(posedge clk_i) disable iff (rst_i) $fell(tx_hold_o));

endmodule : mrc_top
